// ==== logic/buck_sup_pkg.sv ====
// constants, carriers and register map of the buck fault supervisor
package buck_sup_pkg;

	// ***************************************************************
	// timing
	// ***************************************************************
	localparam int unsigned CLK_HZ      = 125_000_000;
	localparam int unsigned FSW_LOW_HZ  = 300_000;
	localparam int unsigned FSW_HIGH_HZ = 600_000;
	localparam int unsigned DUTY_LOW_PCT  = 85;
	localparam int unsigned DUTY_HIGH_PCT = 75;
	localparam int unsigned PER_W = 9;
	localparam logic [PER_W-1:0] PERIOD_LOW  = PER_W'(CLK_HZ / FSW_LOW_HZ);
	localparam logic [PER_W-1:0] PERIOD_HIGH = PER_W'(CLK_HZ / FSW_HIGH_HZ);
	localparam logic [PER_W-1:0] MAX_ON_LOW  = PER_W'((CLK_HZ / FSW_LOW_HZ) * DUTY_LOW_PCT / 100);
	localparam logic [PER_W-1:0] MAX_ON_HIGH =
		PER_W'((CLK_HZ / FSW_HIGH_HZ) * DUTY_HIGH_PCT / 100);
	localparam int unsigned SS_TIME_US  = 4800;
	localparam int unsigned SS_CYCLES   = SS_TIME_US * (CLK_HZ / 1_000_000);
	localparam int unsigned SS_W        = 20;
	localparam int unsigned DUMMY_RUNS  = 2;

	// ***************************************************************
	// register map
	// ***************************************************************
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam int unsigned CTRL_RETRY_BIT = 0;
	localparam int unsigned CTRL_NOUV_BIT  = 1;
	localparam int unsigned CTRL_FAST_BIT  = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// ***************************************************************
	// types
	// ***************************************************************
	typedef enum logic [2:0] {
		ST_OFF      = 3'b000,
		ST_SOFT     = 3'b001,
		ST_RUN      = 3'b010,
		ST_HICCUP   = 3'b011,
		ST_OC_LATCH = 3'b100,
		ST_UV_LATCH = 3'b101
	} phase_type;

	// comparator results, raw from the analog front end
	typedef struct packed {
		logic ov_trip;    // sense above 125 percent
		logic below_half; // sense below 50 percent
		logic uv_trip;    // sense below 75 percent
		logic win_high;   // sense above 110 percent
		logic win_low;    // sense below 90 percent
		logic oc_trip;    // lower switch overcurrent
	} cmp_type;

	typedef struct packed {
		logic       lower_hold;
		phase_type  phase;
		logic       pg_ok;
		logic       oc_pg_low;
		logic       uv_latched;
		logic       ov_latched;
	} status_type;

endpackage

// ==== logic/buck_fault_supervisor.sv ====
// protection, soft-start, hiccup and power-good supervisor for a buck controller
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module buck_fault_supervisor
#(
	parameter int unsigned SS_LEN = buck_sup_pkg::SS_CYCLES
)
(
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire buck_sup_pkg::cmp_type cmp_raw,
	input  wire logic                 enable_pin,
	input  wire logic                 pwm_demand,
	output logic                      upper_switch_drive,
	output logic                      lower_switch_drive,
	output logic                      soft_start_active,
	output logic                      supply_in_window_flag_o,
	output logic                      supply_in_window_flag_oe
);

	// ***************************************************************
	// synchronisers
	// ***************************************************************
	buck_sup_pkg::cmp_type cmp_meta_q;
	buck_sup_pkg::cmp_type cmp_q;
	logic                  en_meta_q;
	logic                  en_q;

	// two stages; only the second stage is read by the fault logic
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cmp_meta_q <= '0;
			cmp_q      <= '0;
			en_meta_q  <= 1'b0;
			en_q       <= 1'b0;
		end
		else
		begin
			cmp_meta_q <= cmp_raw;
			cmp_q      <= cmp_meta_q;
			en_meta_q  <= enable_pin;
			en_q       <= en_meta_q;
		end
	end

	// ***************************************************************
	// register bus
	// ***************************************************************
	logic [2:0]  ctrl_q;
	logic [2:0]  ctrl_d;
	logic        wr_pend_q;
	logic        wr_pend_d;
	logic [7:0]  wr_addr_q;
	logic [7:0]  wr_addr_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        addr_phase;
	buck_sup_pkg::status_type status_now;

	function automatic logic [31:0] read_mux(
		input logic [7:0]               ofs,
		input logic [2:0]               ctrl,
		input buck_sup_pkg::status_type st
	);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (ofs)
			buck_sup_pkg::CTRL_OFS:   r = {29'h0000_0000, ctrl};
			buck_sup_pkg::STATUS_OFS: r = {24'h00_0000, st};
			default:                  r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	assign addr_phase = hsel & htrans[1] & hready;

	// read data is caught in the address phase, so no wait states
	always_comb
	begin
		ctrl_d    = ctrl_q;
		wr_pend_d = addr_phase & hwrite;
		wr_addr_d = addr_phase ? haddr[7:0] : wr_addr_q;
		rdata_d   = rdata_q;
		if (addr_phase & ~hwrite)
			rdata_d = read_mux(haddr[7:0], ctrl_q, status_now);
		if (wr_pend_q && wr_addr_q == buck_sup_pkg::CTRL_OFS)
			ctrl_d = hwdata[2:0];
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ctrl_q    <= buck_sup_pkg::CTRL_RESET;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			rdata_q   <= 32'h0000_0000;
		end
		else
		begin
			ctrl_q    <= ctrl_d;
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			rdata_q   <= rdata_d;
		end
	end

	assign hrdata    = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// variant selection from the control register
	logic retry_mode;
	logic no_uv;
	logic fast_osc;
	assign retry_mode = ctrl_q[buck_sup_pkg::CTRL_RETRY_BIT];
	assign no_uv      = ctrl_q[buck_sup_pkg::CTRL_NOUV_BIT];
	assign fast_osc   = ctrl_q[buck_sup_pkg::CTRL_FAST_BIT];

	// ***************************************************************
	// oscillator and duty limit
	// ***************************************************************
	logic [buck_sup_pkg::PER_W-1:0] per_cnt_q;
	logic [buck_sup_pkg::PER_W-1:0] per_cnt_d;
	logic [buck_sup_pkg::PER_W-1:0] period;
	logic [buck_sup_pkg::PER_W-1:0] max_on;
	logic                           pwm_on;

	assign period = fast_osc ? buck_sup_pkg::PERIOD_HIGH : buck_sup_pkg::PERIOD_LOW;
	assign max_on = fast_osc ? buck_sup_pkg::MAX_ON_HIGH : buck_sup_pkg::MAX_ON_LOW;

	// free-running period counter; no external trim exists
	always_comb
	begin
		if (per_cnt_q >= period - 1'b1)
			per_cnt_d = '0;
		else
			per_cnt_d = per_cnt_q + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			per_cnt_q <= '0;
		else
			per_cnt_q <= per_cnt_d;
	end

	// the modulator request is cut once the duty ceiling is reached
	assign pwm_on = pwm_demand & (per_cnt_q < max_on);

	// ***************************************************************
	// sequencing: soft-start, hiccup, latch-offs
	// ***************************************************************
	buck_sup_pkg::phase_type phase_q;
	buck_sup_pkg::phase_type phase_d;
	logic [buck_sup_pkg::SS_W-1:0] ss_cnt_q;
	logic [buck_sup_pkg::SS_W-1:0] ss_cnt_d;
	logic [1:0]  dummy_q;
	logic [1:0]  dummy_d;
	logic        oc_pg_low_q;
	logic        oc_pg_low_d;
	logic        uv_latch_q;
	logic        uv_latch_d;
	logic        ss_end;
	logic        oc_hit;

	// counted in clk cycles, so both oscillator variants see equal times
	assign ss_end = (ss_cnt_q == SS_LEN[buck_sup_pkg::SS_W-1:0] - 1'b1);
	assign oc_hit = cmp_q.oc_trip & (phase_q == buck_sup_pkg::ST_SOFT
		| phase_q == buck_sup_pkg::ST_RUN);

	always_comb
	begin
		phase_d     = phase_q;
		ss_cnt_d    = ss_cnt_q + 1'b1;
		dummy_d     = dummy_q;
		oc_pg_low_d = oc_pg_low_q;
		uv_latch_d  = uv_latch_q;
		case (phase_q)
			buck_sup_pkg::ST_OFF:
			begin
				ss_cnt_d = '0;
				if (en_q)
					phase_d = buck_sup_pkg::ST_SOFT;
			end
			buck_sup_pkg::ST_SOFT:
			begin
				if (ss_end)
				begin
					phase_d     = buck_sup_pkg::ST_RUN;
					oc_pg_low_d = 1'b0;
				end
			end
			buck_sup_pkg::ST_RUN:
			begin
				ss_cnt_d = '0;
				// overcurrent seen first keeps undervoltage from latching
				if (cmp_q.uv_trip && !no_uv && !oc_pg_low_q && !cmp_q.oc_trip)
				begin
					phase_d    = buck_sup_pkg::ST_UV_LATCH;
					uv_latch_d = 1'b1;
				end
			end
			buck_sup_pkg::ST_HICCUP:
			begin
				// gates stay off while two dummy timeouts run out
				if (ss_end)
				begin
					ss_cnt_d = '0;
					dummy_d  = dummy_q + 1'b1;
					if (dummy_q == 2'(buck_sup_pkg::DUMMY_RUNS - 1))
					begin
						dummy_d = 2'h0;
						phase_d = buck_sup_pkg::ST_SOFT;
					end
				end
			end
			buck_sup_pkg::ST_OC_LATCH:
			begin
				ss_cnt_d = '0;
			end
			buck_sup_pkg::ST_UV_LATCH:
			begin
				ss_cnt_d = '0;
			end
			default:
			begin
				phase_d  = buck_sup_pkg::ST_OFF;
				ss_cnt_d = '0;
			end
		endcase
		if (oc_hit)
		begin
			oc_pg_low_d = 1'b1;
			ss_cnt_d    = '0;
			dummy_d     = 2'h0;
			phase_d = retry_mode ? buck_sup_pkg::ST_HICCUP
				: buck_sup_pkg::ST_OC_LATCH;
		end
		// enable low resets overcurrent, but not the undervoltage latch;
		// a trip in the same cycle still sets the flag, so no event is lost
		if (!en_q && phase_q != buck_sup_pkg::ST_UV_LATCH)
		begin
			phase_d     = buck_sup_pkg::ST_OFF;
			oc_pg_low_d = oc_hit;
			dummy_d     = 2'h0;
			ss_cnt_d    = '0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			phase_q     <= buck_sup_pkg::ST_OFF;
			ss_cnt_q    <= '0;
			dummy_q     <= 2'h0;
			oc_pg_low_q <= 1'b0;
			uv_latch_q  <= 1'b0;
		end
		else
		begin
			phase_q     <= phase_d;
			ss_cnt_q    <= ss_cnt_d;
			dummy_q     <= dummy_d;
			oc_pg_low_q <= oc_pg_low_d;
			uv_latch_q  <= uv_latch_d;
		end
	end

	// ***************************************************************
	// overvoltage latch and lower-switch clamp
	// ***************************************************************
	logic ov_latch_q;
	logic ov_latch_d;
	logic lower_hold_q;
	logic lower_hold_d;

	// armed from reset release in every phase; an open sense pin
	// reads above the trip point and lands here too
	always_comb
	begin
		ov_latch_d   = ov_latch_q | cmp_q.ov_trip;
		lower_hold_d = lower_hold_q;
		if (ov_latch_d)
		begin
			if (cmp_q.ov_trip)
				lower_hold_d = 1'b1;
			else if (cmp_q.below_half)
				lower_hold_d = 1'b0;
		end
	end

	// only power-on reset clears it; the enable pin has no path here
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ov_latch_q   <= 1'b0;
			lower_hold_q <= 1'b0;
		end
		else
		begin
			ov_latch_q   <= ov_latch_d;
			lower_hold_q <= lower_hold_d;
		end
	end

	// ***************************************************************
	// gate drive and power-good
	// ***************************************************************
	logic upper_q;
	logic upper_d;
	logic lower_q;
	logic lower_d;
	logic pg_ok_q;
	logic pg_ok_d;
	logic ss_q;
	logic ss_d;
	logic switching;

	assign switching = phase_d == buck_sup_pkg::ST_SOFT || phase_d == buck_sup_pkg::ST_RUN;

	always_comb
	begin
		upper_d = 1'b0;
		lower_d = 1'b0;
		if (ov_latch_d)
			lower_d = lower_hold_d;
		else if (switching)
		begin
			upper_d = pwm_on;
			lower_d = ~pwm_on;
		end
		ss_d = phase_d == buck_sup_pkg::ST_SOFT;
		// run phase, window comparators and overcurrent only; no protection latch
		pg_ok_d = phase_d == buck_sup_pkg::ST_RUN
			&& !cmp_q.win_high
			&& !cmp_q.win_low
			&& !oc_pg_low_d;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			upper_q <= 1'b0;
			lower_q <= 1'b0;
			pg_ok_q <= 1'b0;
			ss_q    <= 1'b0;
		end
		else
		begin
			upper_q <= upper_d;
			lower_q <= lower_d;
			pg_ok_q <= pg_ok_d;
			ss_q    <= ss_d;
		end
	end

	assign upper_switch_drive       = upper_q;
	assign lower_switch_drive       = lower_q;
	assign soft_start_active        = ss_q;
	assign supply_in_window_flag_o  = 1'b0; // open drain: pulls low only
	assign supply_in_window_flag_oe = ~pg_ok_q;

	assign status_now = '{
		lower_hold: lower_hold_q,
		phase:      phase_q,
		pg_ok:      pg_ok_q,
		oc_pg_low:  oc_pg_low_q,
		uv_latched: uv_latch_q,
		ov_latched: ov_latch_q
	};

endmodule
`default_nettype wire

// ==== tb/buck_sup_sva.sv ====
// port assertions for the buck fault supervisor
`timescale 1ns/10ps
`default_nettype none
module buck_sup_sva
(
	input	wire logic			clk,
	input	wire logic			sys_rst,
	input	wire logic			hreadyout,
	input	wire logic			hresp,
	input	wire buck_sup_pkg::cmp_type	cmp_raw,
	input	wire logic			enable_pin,
	input	wire logic			upper_switch_drive,
	input	wire logic			lower_switch_drive,
	input	wire logic			soft_start_active,
	input	wire logic			supply_in_window_flag_o,
	input	wire logic			supply_in_window_flag_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic	[8:0]	on_q;
	logic	[8:0]	on_d;
	// length of the current upper on-time
	always_comb on_d = upper_switch_drive ? on_q + 9'h001 : 9'h000;
	// registered only, cleared by reset
	always_ff @(posedge clk) on_q <= sys_rst ? 9'h000 : on_d;
	// five samples cover sync depth plus output flop
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	od_data_a: assert property (!supply_in_window_flag_o)
		else $error("open drain data not low");
	no_overlap_a: assert property (!(upper_switch_drive && lower_switch_drive))
		else $error("both switches on");
	ov_clamp_a: assert property (cmp_raw.ov_trip [*5] |->
		!upper_switch_drive && lower_switch_drive) else $error("no overvoltage clamp");
	oc_pg_low_a: assert property (cmp_raw.oc_trip [*3] |=> supply_in_window_flag_oe)
		else $error("overcurrent left good flag");
	hi_pg_low_a: assert property (cmp_raw.win_high [*5] |-> supply_in_window_flag_oe)
		else $error("high window left good flag");
	lo_pg_low_a: assert property (cmp_raw.win_low [*5] |-> supply_in_window_flag_oe)
		else $error("low window left good flag");
	soft_pg_low_a: assert property (soft_start_active |-> supply_in_window_flag_oe)
		else $error("good flag during ramp");
	ramp_release_a: assert property ((enable_pin && !cmp_raw.win_high &&
		!cmp_raw.win_low && !cmp_raw.oc_trip) [*5] ##0 $fell(soft_start_active)
		|-> !supply_in_window_flag_oe) else $error("good flag late after ramp");
	duty_limit_a: assert property (on_q <= 9'(buck_sup_pkg::MAX_ON_LOW))
		else $error("upper on time too long");
	cover property ($fell(soft_start_active));
	cover property (cmp_raw.ov_trip [*5]);
	cover property (cmp_raw.oc_trip [*3]);
endmodule
`default_nettype wire

// ==== tb/buck_power_stage.sv ====
// sense pin and comparator model, with lower-switch current sensing
`timescale 1ns/10ps
`default_nettype none
module buck_power_stage
(
	input	wire logic [7:0]		pct,
	input	wire logic			open_sense,
	input	wire logic			short_load,
	input	wire logic			lower_switch_drive,
	output	wire buck_sup_pkg::cmp_type	cmp_raw
);
	logic	[7:0]	v;
	// a floating sense pin drifts high on its bias current
	assign v = open_sense ? 8'hff : pct;
	// comparator ladder in percent of reference
	assign cmp_raw.ov_trip = v > 8'h7d;
	assign cmp_raw.below_half = v < 8'h32;
	assign cmp_raw.uv_trip = v < 8'h4b;
	assign cmp_raw.win_high = v > 8'h6e;
	assign cmp_raw.win_low = v < 8'h5a;
	// current is only sensed while the lower switch conducts
	assign cmp_raw.oc_trip = short_load && lower_switch_drive;
endmodule
`default_nettype wire

// ==== tb/buck_fault_supervisor_bench.sv ====
// self-checking bench for the buck fault supervisor
`timescale 1ns/10ps
`default_nettype none
module buck_fault_supervisor_bench;
	localparam int SS = 50;
	logic			clk = 1'b0;
	logic			sys_rst = 1'b1;
	logic			hsel = 1'b0;
	logic	[31:0]		haddr = 32'h0;
	logic	[1:0]		htrans = 2'h0;
	logic			hwrite = 1'b0;
	logic	[31:0]		hwdata = 32'h0;
	logic			enable_pin = 1'b0;
	logic			pwm_demand = 1'b0;
	logic			open_sense = 1'b0;
	logic			short_load = 1'b0;
	logic	[7:0]		pct = 8'h64;
	logic			hready;
	logic			hreadyout;
	logic			hresp;
	logic			up;
	logic			lo;
	logic			ss;
	logic			pg_o;
	logic			pg_oe;
	logic	[31:0]		hrdata;
	buck_sup_pkg::cmp_type	cmp;
	logic	[31:0]		rd;
	int			n;
	int			n_errors = 0;
	int			total_checks = 0;
	logic	[7:0]		pv[9] = '{8'h73, 8'h55, 8'h64, 8'h82, 8'h73, 8'h2d, 8'h64, 8'h82, 8'h64};
	logic	[2:0]		pe[9] = '{3'h3, 3'h3, 3'h2, 3'h3, 3'h3, 3'h1, 3'h0, 3'h3, 3'h2};
	assign hready = hreadyout;
	// free-running clock, 8 ns
	always #4 clk = ~clk;
	buck_fault_supervisor #(.SS_LEN(SS)) buck_fault_supervisor_i (.clk(clk), .sys_rst(sys_rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cmp_raw(cmp), .enable_pin(enable_pin), .pwm_demand(pwm_demand),
		.upper_switch_drive(up), .lower_switch_drive(lo), .soft_start_active(ss),
		.supply_in_window_flag_o(pg_o), .supply_in_window_flag_oe(pg_oe));
	buck_power_stage buck_power_stage_i (.pct(pct), .open_sense(open_sense),
		.short_load(short_load), .lower_switch_drive(lo), .cmp_raw(cmp));
	task close_out;
		if (n_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk_reg(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk_pin(input logic g, input logic e);
		chk_reg({31'h0, g}, {31'h0, e});
	endtask
	// bounded waits; a spent bound ends the run
	task step;
		n = 0;
		@(posedge clk);
		while (hready !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				n_errors++;
				close_out;
			end
			@(posedge clk);
		end
	endtask
	task wait_soft(input logic lv);
		n = 0;
		while (ss !== lv)
		begin
			@(posedge clk);
			n++;
			if (n > 4 * SS)
			begin
				n_errors++;
				close_out;
			end
		end
	endtask
	// one single-word transfer, read data taken at the data-phase edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		step;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		step;
		rd = hrdata;
	endtask
	// phase and the three fault flags of status
	task phase(input logic [2:0] p, input logic [2:0] f);
		bus(1'b0, buck_sup_pkg::STATUS_OFS, 32'h0);
		chk_reg({26'h0, rd[6:4], rd[2:0]}, {26'h0, p, f});
	endtask
	task settle;
		repeat (5) @(posedge clk);
	endtask
	task rst;
		sys_rst <= 1'b1;
		enable_pin <= 1'b0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
	endtask
	task start(input logic [31:0] c);
		bus(1'b1, buck_sup_pkg::CTRL_OFS, c);
		enable_pin <= 1'b1;
		wait_soft(1'b1);
		wait_soft(1'b0);
	endtask
	// upper on-cycles over one switching period
	task duty(input int per, input int on);
		repeat (416) @(posedge clk);
		n = 0;
		repeat (per)
		begin
			@(posedge clk);
			n += up;
		end
		chk_reg(32'(n), 32'(on));
	endtask
	initial
	begin
		rst;
		chk_reg({29'h0, up, lo, pg_oe}, 32'h1);
		bus(1'b0, buck_sup_pkg::CTRL_OFS, 32'h0);
		chk_reg(rd, {29'h0, buck_sup_pkg::CTRL_RESET});
		bus(1'b0, 8'h08, 32'h0);
		chk_reg(rd, 32'h0);
		bus(1'b1, buck_sup_pkg::CTRL_OFS, 32'h0);
		enable_pin <= 1'b1;
		wait_soft(1'b1);
		chk_pin(pg_oe, 1'b1);
		wait_soft(1'b0);
		chk_pin(n >= SS - 1 && n <= SS + 1, 1'b1);
		chk_pin(pg_oe, 1'b0);
		phase(3'h2, 3'h0);
		pwm_demand <= 1'b1;
		duty(416, 353);
		bus(1'b1, buck_sup_pkg::CTRL_OFS, 32'h4);
		duty(208, 156);
		pwm_demand <= 1'b0;
		bus(1'b1, buck_sup_pkg::CTRL_OFS, 32'h2);
		// window steps, then overvoltage clamp and release; undervoltage off so
		// the dip to 45 percent exercises the clamp release and not a latch-off
		for (int i = 0; i < 9; i++)
		begin
			pct <= pv[i];
			settle;
			chk_reg({29'h0, up, lo, pg_oe}, {29'h0, pe[i]});
		end
		phase(3'h2, 3'h1);
		enable_pin <= 1'b0;
		settle;
		enable_pin <= 1'b1;
		settle;
		bus(1'b0, buck_sup_pkg::STATUS_OFS, 32'h0);
		chk_pin(rd[0], 1'b1);
		rst;
		phase(3'h0, 3'h0);
		open_sense <= 1'b1;
		settle;
		chk_reg({30'h0, up, lo}, 32'h1);
		open_sense <= 1'b0;
		rst;
		start(32'h2);
		pct <= 8'h46;
		settle;
		phase(3'h2, 3'h0);
		bus(1'b1, buck_sup_pkg::CTRL_OFS, 32'h0);
		settle;
		phase(3'h5, 3'h2);
		chk_reg({30'h0, up, lo}, 32'h0);
		enable_pin <= 1'b0;
		settle;
		phase(3'h5, 3'h2);
		pct <= 8'h64;
		rst;
		// latching overcurrent blocks undervoltage, cleared by enable
		start(32'h0);
		short_load <= 1'b1;
		pct <= 8'h46;
		settle;
		phase(3'h4, 3'h4);
		chk_reg({29'h0, up, lo, pg_oe}, 32'h1);
		settle;
		phase(3'h4, 3'h4);
		pct <= 8'h64;
		short_load <= 1'b0;
		enable_pin <= 1'b0;
		settle;
		phase(3'h0, 3'h0);
		// retry variant: trip in ramp, two dummy timeouts, good ramp
		bus(1'b1, buck_sup_pkg::CTRL_OFS, 32'h1);
		short_load <= 1'b1;
		start(32'h1);
		short_load <= 1'b0;
		phase(3'h3, 3'h4);
		chk_reg({30'h0, up, lo}, 32'h0);
		wait_soft(1'b1);
		chk_pin(n >= 2 * SS - 12 && n <= 2 * SS + 4, 1'b1);
		wait_soft(1'b0);
		chk_pin(pg_oe, 1'b0);
		phase(3'h2, 3'h0);
		close_out;
	end
endmodule
bind buck_fault_supervisor buck_sup_sva buck_sup_sva_i (.clk(clk), .sys_rst(sys_rst),
	.hreadyout(hreadyout), .hresp(hresp), .cmp_raw(cmp_raw), .enable_pin(enable_pin),
	.upper_switch_drive(upper_switch_drive), .lower_switch_drive(lower_switch_drive),
	.soft_start_active(soft_start_active), .supply_in_window_flag_o(supply_in_window_flag_o),
	.supply_in_window_flag_oe(supply_in_window_flag_oe));
`default_nettype wire
